// >>> logic/wolf_defs.vh
// Purpose: shared constants of the wake-on-lan receive filter
// Assumes: register indices are word indices, byte address = 4 * index
// Notes:   definitions only
`ifndef WOLF_DEFS_VH
`define WOLF_DEFS_VH
// ****************************************************************
// register indices
// ****************************************************************
`define WOLF_IDX_CFG     11'h4a0
`define WOLF_IDX_STAT    11'h4a1
`define WOLF_IDX_BANK0   11'h4a2
`define WOLF_IDX_BANKN   11'h4aa
// ****************************************************************
// configuration fields
// ****************************************************************
`define WOLF_CFG_RST     16'h1000
`define WOLF_CFG_SWAP_LO 14
`define WOLF_CFG_SFD     13
`define WOLF_CFG_CRCG    12
`define WOLF_CFG_CLR     11
`define WOLF_CFG_PLEN_LO 9
`define WOLF_CFG_LEVEL   8
`define WOLF_CFG_WOLEN   7
`define WOLF_CFG_SECURE  5
`define WOLF_CFG_PATEN   1
`define WOLF_CFG_MAGEN   0
// ****************************************************************
// status fields
// ****************************************************************
`define WOLF_ST_SRC      12
`define WOLF_ST_CRC      6
`define WOLF_ST_HACK     5
`define WOLF_ST_PAT      1
`define WOLF_ST_MAGIC    0
// ****************************************************************
// frame constants and timing
// ****************************************************************
`define WOLF_SFD_NORM    8'hd5
`define WOLF_SFD_ALT     8'h5d
`define WOLF_SYNC_BYTE   8'hff
`define WOLF_SYNC_LEN    3'h6
`define WOLF_DA_LAST_REP 4'hf
`define WOLF_LAST_BYTE   3'h5
`define WOLF_PULSE_BASE  7'h08
`endif

// >>> logic/wolf_ind.v
// Purpose: shapes wake events into a pulse or a held level
// Assumes: evt_i is a one-cycle pulse
// Notes:   a new event restarts a running pulse
`timescale 1ns/100ps
`include "wolf_defs.vh"
module wolf_ind (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       evt_i,
  input  wire       level_i,
  input  wire [1:0] sel_i,
  input  wire       clr_i,
  output reg        ind_o
);
  reg  [6:0] cnt_r;
  wire [6:0] len = `WOLF_PULSE_BASE << sel_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ind_o <= 1'b0;
      cnt_r <= 7'h00;
    end else if (evt_i) begin
      // event wins over a clear in the same cycle
      ind_o <= 1'b1;
      cnt_r <= len - 7'h01;
    end else if (level_i) begin
      if (clr_i) begin
        ind_o <= 1'b0;
      end
    end else if (cnt_r != 7'h00) begin
      cnt_r <= cnt_r - 7'h01;
    end else begin
      ind_o <= 1'b0;
    end
  end
endmodule

// >>> logic/wolf_rx_filter.v
// Purpose: wake-on-lan receive filter with a classic wishbone slave
// Assumes: receive byte stream and polarity events come from logic on clk_i
// Notes:   clk_i stands for the internal 125-mhz indication clock
//
// What this block does
// - Received bytes are reordered by the swap field: none, reversed bits, swapped nibbles, or reversed nibble bits.
// - The matcher hunts for delimiter 0xd5, or 0x5d when the delimiter-select bit is set.
// - With the crc-gate bit set (its reset value) a bad-crc frame gives no magic or pattern indication anywhere.
// - Writing one to the self-clearing clear bit drops a held level indication; the bit reads back zero.
// - A pulse indication lasts 8, 16, 32 or 64 clocks for codes 0 to 3, and the field is ignored in level mode.
// - The mode bit picks a held level when set and a fixed pulse when clear.
// - The wake enable bit turns frame detection on; clear leaves plain operation with no detection.
// - The password-enable bit makes a magic packet valid only when followed by the six configured password bytes.
// - The pattern-enable bit raises the interrupt indication when a frame holds the configured pattern.
// - The magic-enable bit raises the interrupt indication on a valid magic packet.
// - Sticky clear-on-read status flags record a valid magic packet and a pattern frame.
// - A sticky clear-on-read flag records a magic packet whose password is wrong.
// - Turning wake detection on switches the interrupt source from polarity events to wake events.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "wolf_defs.vh"
module wolf_rx_filter (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg         wb_ack_o,
  output reg  [31:0] wb_dat_o,
  input  wire        rx_vld_i,
  input  wire [7:0]  rx_data_i,
  input  wire        rx_end_i,
  input  wire        rx_crc_bad_i,
  input  wire        pol_evt_i,
  output reg         int_o,
  output wire        wake_o
);
// ****************************************************************
// states
// ****************************************************************
  localparam ST_IDLE = 5'h01;
  localparam ST_SYNC = 5'h02;
  localparam ST_DA   = 5'h04;
  localparam ST_PWD  = 5'h08;
  localparam ST_DONE = 5'h10;
// ****************************************************************
// registers
// ****************************************************************
  reg  [15:0] cfg_r;
  reg         src_r;
  reg         magic_f_r;
  reg         pat_f_r;
  reg         hack_f_r;
  reg         crc_f_r;
  reg  [15:0] bank_r [0:8];
  reg  [4:0]  st_r;
  reg  [2:0]  ff_cnt_r;
  reg  [2:0]  idx_r;
  reg  [3:0]  rep_r;
  reg         pw_ok_r;
  reg         magic_seen_r;
  reg         pw_bad_r;
  reg         pat_hit_r;
  reg  [47:0] win_r;
  reg  [2:0]  win_cnt_r;
  integer     i;
// ****************************************************************
// bus decode
// ****************************************************************
  wire [10:0] widx   = wb_adr_i[12:2];
  wire        req    = wb_cyc_i & wb_stb_i;
  wire        take   = req & wb_ack_o;
  wire        wr     = take & wb_we_i;
  wire        rd     = take & ~wb_we_i;
  wire        in_bnk = (widx >= `WOLF_IDX_BANK0) && (widx <= `WOLF_IDX_BANKN);
  wire [3:0]  bsel   = widx[3:0] - 4'h2;
  wire [15:0] wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        wr_cfg = wr && (widx == `WOLF_IDX_CFG);
  wire        wr_st  = wr && (widx == `WOLF_IDX_STAT) && wb_sel_i[1];
  wire        rd_st  = rd && (widx == `WOLF_IDX_STAT);
  wire [15:0] cfg_w  = (cfg_r & ~wmask) | (wb_dat_i[15:0] & wmask);
  wire        clr_p  = wr_cfg & wb_sel_i[1] & wb_dat_i[`WOLF_CFG_CLR];
  wire        wol_en = cfg_r[`WOLF_CFG_WOLEN];
  wire        secure = cfg_r[`WOLF_CFG_SECURE];
  wire [15:0] stat_w = {3'h0, src_r, 5'h00, crc_f_r, hack_f_r, 3'h0, pat_f_r, magic_f_r};
// ****************************************************************
// byte reorder stage
// ****************************************************************
  wire       sb_vld;
  wire [7:0] sb_dat;
  wire       sb_end;
  wire       sb_crc;
  wolf_swap u_swap (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mode_i    (cfg_r[`WOLF_CFG_SWAP_LO+1:`WOLF_CFG_SWAP_LO]),
    .vld_i     (rx_vld_i),
    .dat_i     (rx_data_i),
    .end_i     (rx_end_i),
    .crc_bad_i (rx_crc_bad_i),
    .vld_o     (sb_vld),
    .dat_o     (sb_dat),
    .end_o     (sb_end),
    .crc_bad_o (sb_crc)
  );
// ****************************************************************
// match data views
// ****************************************************************
  wire [47:0] da_w   = {bank_r[2], bank_r[1], bank_r[0]};
  wire [47:0] pw_w   = {bank_r[5], bank_r[4], bank_r[3]};
  wire [47:0] pt_w   = {bank_r[8], bank_r[7], bank_r[6]};
  wire [5:0]  da_bas = 6'h2f - {idx_r, 3'h0};
  wire [7:0]  da_b   = da_w[da_bas -: 8];
  wire [7:0]  pw_b   = pw_w[{idx_r, 3'h0} +: 8];
  wire [47:0] pt_ord;
  wire [47:0] win_nx = {win_r[39:0], sb_dat};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_pat
      assign pt_ord[47-8*g -: 8] = pt_w[8*g +: 8];
    end
  endgenerate
  wire [7:0]  sfd    = cfg_r[`WOLF_CFG_SFD] ? `WOLF_SFD_ALT : `WOLF_SFD_NORM;
  wire        is_ff  = (sb_dat == `WOLF_SYNC_BYTE);
  wire        pw_end = pw_ok_r && (sb_dat == pw_b);
// ****************************************************************
// frame verdict
// ****************************************************************
  // crc gate
  wire        f_ok   = ~(cfg_r[`WOLF_CFG_CRCG] & sb_crc);
  wire        fin    = sb_end & wol_en & ~st_r[0];
  wire        m_good = fin & f_ok & magic_seen_r;
  wire        p_good = fin & f_ok & pat_hit_r;
  wire        h_set  = fin & f_ok & (pw_bad_r | st_r[3]);
  wire        c_set  = fin & sb_crc;
  wire        m_evt  = m_good & cfg_r[`WOLF_CFG_MAGEN];
  wire        p_evt  = p_good & cfg_r[`WOLF_CFG_PATEN];
// ****************************************************************
// wishbone slave and register file
// ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      cfg_r     <= `WOLF_CFG_RST;
      src_r     <= 1'b0;
      magic_f_r <= 1'b0;
      pat_f_r   <= 1'b0;
      hack_f_r  <= 1'b0;
      crc_f_r   <= 1'b0;
      int_o     <= 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
        bank_r[i] <= 16'h0000;
      end
    end else begin
      // one wait state; unmapped words read zero and ignore writes
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (widx == `WOLF_IDX_CFG) begin
        wb_dat_o[15:0] <= cfg_r;
      end else if (widx == `WOLF_IDX_STAT) begin
        wb_dat_o[15:0] <= stat_w;
      end else if (in_bnk) begin
        wb_dat_o[15:0] <= bank_r[bsel];
      end
      if (wr_cfg) begin
        cfg_r <= cfg_w & ~(16'h0001 << `WOLF_CFG_CLR);
      end
      for (i = 0; i < 9; i = i + 1) begin
        if (wr && in_bnk && (bsel == i[3:0])) begin
          bank_r[i] <= (bank_r[i] & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
      end
      if (wr_cfg && cfg_w[`WOLF_CFG_WOLEN] && !wol_en) begin
        src_r <= 1'b1;
      end else if (wr_st) begin
        src_r <= wb_dat_i[`WOLF_ST_SRC];
      end
      // sticky flags, set beats read clear
      // a read clears only what it returned, so a flag set during the read survives
      magic_f_r <= m_good | (magic_f_r & ~(rd_st & wb_dat_o[`WOLF_ST_MAGIC]));
      pat_f_r   <= p_good | (pat_f_r & ~(rd_st & wb_dat_o[`WOLF_ST_PAT]));
      hack_f_r  <= h_set | (hack_f_r & ~(rd_st & wb_dat_o[`WOLF_ST_HACK]));
      crc_f_r   <= c_set | (crc_f_r & ~(rd_st & wb_dat_o[`WOLF_ST_CRC]));
      int_o <= src_r ? (m_evt | p_evt) : pol_evt_i;
    end
  end
// ****************************************************************
// frame matcher
// ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r         <= ST_IDLE;
      ff_cnt_r     <= 3'h0;
      idx_r        <= 3'h0;
      rep_r        <= 4'h0;
      pw_ok_r      <= 1'b0;
      magic_seen_r <= 1'b0;
      pw_bad_r     <= 1'b0;
      pat_hit_r    <= 1'b0;
      win_r        <= 48'h000000000000;
      win_cnt_r    <= 3'h0;
    end else if (!wol_en || sb_end) begin
      st_r <= ST_IDLE;
    end else if (sb_vld) begin
      if (!st_r[0]) begin
        win_r <= win_nx;
        if (win_cnt_r != `WOLF_SYNC_LEN) begin
          win_cnt_r <= win_cnt_r + 3'h1;
        end
        if ((win_cnt_r >= `WOLF_LAST_BYTE) && (win_nx == pt_ord)) begin
          pat_hit_r <= 1'b1;
        end
      end
      case (st_r)
        ST_IDLE: begin
          if (sb_dat == sfd) begin
            st_r         <= ST_SYNC;
            ff_cnt_r     <= 3'h0;
            idx_r        <= 3'h0;
            rep_r        <= 4'h0;
            magic_seen_r <= 1'b0;
            pw_bad_r     <= 1'b0;
            pat_hit_r    <= 1'b0;
            win_cnt_r    <= 3'h0;
          end
        end
        ST_SYNC: begin
          // sync run then address
          // an address starting with 0xff is not recognised here
          if (is_ff) begin
            if (ff_cnt_r != `WOLF_SYNC_LEN) begin
              ff_cnt_r <= ff_cnt_r + 3'h1;
            end
          end else if ((ff_cnt_r == `WOLF_SYNC_LEN) && (sb_dat == da_b)) begin
            st_r  <= ST_DA;
            idx_r <= 3'h1;
          end else begin
            ff_cnt_r <= 3'h0;
          end
        end
        ST_DA: begin
          if (sb_dat != da_b) begin
            st_r     <= ST_SYNC;
            ff_cnt_r <= is_ff ? 3'h1 : 3'h0;
            idx_r    <= 3'h0;
            rep_r    <= 4'h0;
          end else if (idx_r != `WOLF_LAST_BYTE) begin
            idx_r <= idx_r + 3'h1;
          end else begin
            idx_r <= 3'h0;
            rep_r <= rep_r + 4'h1;
            if (rep_r == `WOLF_DA_LAST_REP) begin
              if (secure) begin
                st_r    <= ST_PWD;
                pw_ok_r <= 1'b1;
              end else begin
                st_r         <= ST_DONE;
                magic_seen_r <= 1'b1;
              end
            end
          end
        end
        ST_PWD: begin
          pw_ok_r <= pw_end;
          idx_r   <= idx_r + 3'h1;
          if (idx_r == `WOLF_LAST_BYTE) begin
            st_r         <= ST_DONE;
            magic_seen_r <= pw_end;
            pw_bad_r     <= ~pw_end;
          end
        end
        ST_DONE: begin
          st_r <= ST_DONE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
// ****************************************************************
// wake indication
// ****************************************************************
  wolf_ind u_ind (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .evt_i   (m_evt | p_evt),
    .level_i (cfg_r[`WOLF_CFG_LEVEL]),
    .sel_i   (cfg_r[`WOLF_CFG_PLEN_LO+1:`WOLF_CFG_PLEN_LO]),
    .clr_i   (clr_p),
    .ind_o   (wake_o)
  );
endmodule

// >>> logic/wolf_swap.v
// Purpose: reorders each received byte before matching
// Assumes: byte stream from receive logic on clk_i
// Notes:   one register stage, all strobes delayed alike
`timescale 1ns/100ps
module wolf_swap (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [1:0] mode_i,
  input  wire       vld_i,
  input  wire [7:0] dat_i,
  input  wire       end_i,
  input  wire       crc_bad_i,
  output reg        vld_o,
  output reg  [7:0] dat_o,
  output reg        end_o,
  output reg        crc_bad_o
);
  wire [7:0] rev_all;
  wire [7:0] rev_nib;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rev
      assign rev_all[g] = dat_i[7-g];
      assign rev_nib[g] = dat_i[(g & 4) + 3 - (g & 3)];
    end
  endgenerate
  always @(posedge clk_i) begin
    if (rst_i) begin
      vld_o     <= 1'b0;
      dat_o     <= 8'h00;
      end_o     <= 1'b0;
      crc_bad_o <= 1'b0;
    end else begin
      vld_o     <= vld_i;
      end_o     <= end_i;
      crc_bad_o <= crc_bad_i;
      case (mode_i)
        2'h1:    dat_o <= rev_all;
        2'h2:    dat_o <= {dat_i[3:0], dat_i[7:4]};
        2'h3:    dat_o <= rev_nib;
        default: dat_o <= dat_i;
      endcase
    end
  end
endmodule

// >>> test/wolf_rx_filter_properties.sv
// Purpose: concurrent checks on the ports of the receive filter
// Assumes: a shadow of the config register follows acknowledged writes
// Notes:   pulse length check assumes no event restarts a running pulse
`timescale 1ns/100ps
`include "wolf_defs.vh"
module wolf_rx_filter_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        rx_vld_i,
  input wire [7:0]  rx_data_i,
  input wire        rx_end_i,
  input wire        rx_crc_bad_i,
  input wire        pol_evt_i,
  input wire        int_o,
  input wire        wake_o
);
  // ************************
  // config shadow, pulse counter
  // ************************
  reg  [15:0] cfg_r;
  reg  [6:0]  hi_r;
  wire        cfg_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[12:2] == `WOLF_IDX_CFG;
  wire        clr_wr = cfg_wr && wb_dat_i[`WOLF_CFG_CLR];
  always @(posedge clk_i) begin
    if (rst_i)
      cfg_r <= `WOLF_CFG_RST;
    else if (cfg_wr)
      cfg_r <= wb_dat_i[15:0];
    if (rst_i || !wake_o)
      hi_r <= 7'h00;
    else
      hi_r <= hi_r + 7'h01;
  end
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ************************
  // assertions
  // ************************
  chk_ack_delay: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_clr_reads: assert property (wb_ack_o && !wb_we_i && wb_adr_i[12:2] == `WOLF_IDX_CFG |-> !wb_dat_o[11])
    else $error("clear bit reads back one");
  chk_clr_level: assert property (clr_wr && cfg_r[`WOLF_CFG_LEVEL] |-> ##[1:2] !wake_o)
    else $error("level indication not cleared");
  chk_level_hold: assert property (cfg_r[8] && wake_o && !cfg_wr && !$past(cfg_wr) |=> wake_o)
    else $error("level indication dropped");
  chk_pulse_len: assert property ($fell(wake_o) && !cfg_r[8] |-> hi_r == (7'h08 << cfg_r[10:9]))
    else $error("pulse length wrong");
  chk_wake_off: assert property (!cfg_r[7] && !$past(cfg_r[7], 2) |-> !$rose(wake_o))
    else $error("wake while detection disabled");
  chk_crc_gate: assert property (rx_end_i && rx_crc_bad_i && cfg_r[12] |-> ##2 !$rose(wake_o))
    else $error("bad crc frame gave wake");
  chk_wake_int: assert property ($rose(wake_o) && cfg_r[7] |-> int_o)
    else $error("wake without interrupt");
  chk_wake_time: assert property ($rose(wake_o) |-> $past(rx_end_i, 2))
    else $error("wake not two cycles after frame end");
  cover property ($rose(wake_o) && cfg_r[`WOLF_CFG_LEVEL]);
  cover property (clr_wr && wake_o);
  cover property (rx_end_i && rx_crc_bad_i && cfg_r[`WOLF_CFG_CRCG]);
endmodule

bind wolf_rx_filter wolf_rx_filter_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_vld_i(rx_vld_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i),
  .rx_crc_bad_i(rx_crc_bad_i), .pol_evt_i(pol_evt_i), .int_o(int_o), .wake_o(wake_o));

// >>> test/wolf_rx_filter_tb_top.sv
// Purpose: self-checking bench for the wake-on-lan receive filter
// Assumes: the station model drives the receive stream
// Notes:   counts of wake and interrupt cycles are taken after each frame
`timescale 1ns/100ps
`include "wolf_defs.vh"
module wolf_rx_filter_tb_top;
  localparam [47:0] ADDR = 48'h021122334455;
  localparam [47:0] PW   = 48'ha0a1a2a3a4a5;
  localparam [47:0] PAT  = 48'hc0c1c2c3c4c5;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pol_evt_i, int_o, wake_o;
  logic        rx_vld_i, rx_end_i, rx_crc_bad_i;
  logic [7:0]  rx_data_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [1:0]  swap_r;
  integer      failures, num_checks, cyc_n, m, k;
  wolf_rx_filter dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .rx_vld_i(rx_vld_i), .rx_data_i(rx_data_i), .rx_end_i(rx_end_i),
    .rx_crc_bad_i(rx_crc_bad_i), .pol_evt_i(pol_evt_i), .int_o(int_o), .wake_o(wake_o));
  wolf_station_model #(.ADDR(ADDR), .PW(PW), .PAT(PAT)) stn_u (.clk_i(clk_i), .swap_i(swap_r),
    .rx_vld_o(rx_vld_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .rx_crc_bad_o(rx_crc_bad_i));
  // ************************
  // clock, timeout, tasks
  // ************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      complete_run;
    end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // the slave answer time is not assumed; only the bench timeout ends a wait
  task wb_xfer(input logic we, input logic [10:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h3;
    wb_adr_i <= {19'h00000, idx, 2'b00};
    wb_dat_i <= {16'h0000, wd};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wr(input logic [10:0] idx, input logic [15:0] wd);
    logic [15:0] rd;
    wb_xfer(1'b1, idx, wd, rd);
  endtask
  task rdc(input logic [10:0] idx, input logic [15:0] exp);
    logic [15:0] rd;
    wb_xfer(1'b0, idx, 16'h0000, rd);
    chk_val(rd, exp);
  endtask
  task pol(input logic [15:0] ei);
    logic [15:0] ic;
    ic = 16'h0000;
    @(posedge clk_i);
    pol_evt_i <= 1'b1;
    @(posedge clk_i);
    pol_evt_i <= 1'b0;
    repeat (6) begin
      #1 ic += int_o;
      @(posedge clk_i);
    end
    chk_val(ic, ei);
  endtask
  // ew of all ones skips the wake count, for level mode
  task frame(input [7:0] sfd, input [1:0] kind, input bad, input logic [15:0] ew, ei, est);
    logic [15:0] w, ic;
    w = 16'h0000;
    ic = 16'h0000;
    stn_u.send(sfd, kind, bad);
    repeat (90) begin
      #1 w += wake_o;
      ic += int_o;
      @(posedge clk_i);
    end
    if (ew !== 16'hffff)
      chk_val(w, ew);
    chk_val(ic, ei);
    rdc(`WOLF_IDX_STAT, est);
    rdc(`WOLF_IDX_STAT, est & 16'h1000);
  endtask
  // ************************
  // main sequence
  // ************************
  initial begin
    {failures, num_checks, cyc_n} = 0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pol_evt_i} = 5'h10;
    {wb_adr_i, wb_dat_i, wb_sel_i, swap_r} = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`WOLF_IDX_CFG, 16'h1000);
    rdc(`WOLF_IDX_STAT, 16'h0000);
    rdc(`WOLF_IDX_BANK0, 16'h0000);
    wr(11'h4b0, 16'hffff);
    rdc(11'h4b0, 16'h0000);
    wr(`WOLF_IDX_CFG, 16'h185c);
    rdc(`WOLF_IDX_CFG, 16'h105c);
    for (k = 0; k < 3; k++) begin
      wr(`WOLF_IDX_BANK0 + 11'h2 - k[10:0], ADDR[47-16*k -: 16]);
      wr(`WOLF_IDX_BANK0 + 11'h3 + k[10:0], {PW[39-16*k -: 8], PW[47-16*k -: 8]});
      wr(`WOLF_IDX_BANK0 + 11'h6 + k[10:0], {PAT[39-16*k -: 8], PAT[47-16*k -: 8]});
    end
    rdc(`WOLF_IDX_BANKN, 16'hc5c4);
    wr(`WOLF_IDX_CFG, 16'h1003);
    frame(8'hd5, 2'd0, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    pol(16'h0001);
    for (m = 0; m < 4; m++) begin
      swap_r <= m[1:0];
      wr(`WOLF_IDX_CFG, {m[1:0], 3'b010, m[1:0], 9'h081});
      frame(8'hd5, 2'd0, 1'b0, 16'h0008 << m, 16'h0001, 16'h1001);
    end
    swap_r <= 2'b00;
    pol(16'h0000);
    wr(`WOLF_IDX_STAT, 16'h0000);
    rdc(`WOLF_IDX_STAT, 16'h0000);
    pol(16'h0001);
    wr(`WOLF_IDX_STAT, 16'h1000);
    wr(`WOLF_IDX_CFG, 16'h3081);
    frame(8'h5d, 2'd0, 1'b0, 16'h0008, 16'h0001, 16'h1001);
    frame(8'hd5, 2'd0, 1'b0, 16'h0000, 16'h0000, 16'h1000);
    wr(`WOLF_IDX_CFG, 16'h1081);
    frame(8'hd5, 2'd0, 1'b1, 16'h0000, 16'h0000, 16'h1040);
    wr(`WOLF_IDX_CFG, 16'h0081);
    frame(8'hd5, 2'd0, 1'b1, 16'h0008, 16'h0001, 16'h1041);
    wr(`WOLF_IDX_CFG, 16'h10a1);
    frame(8'hd5, 2'd1, 1'b0, 16'h0008, 16'h0001, 16'h1001);
    frame(8'hd5, 2'd2, 1'b0, 16'h0000, 16'h0000, 16'h1020);
    wr(`WOLF_IDX_CFG, 16'h1082);
    frame(8'hd5, 2'd3, 1'b0, 16'h0008, 16'h0001, 16'h1002);
    frame(8'hd5, 2'd0, 1'b0, 16'h0000, 16'h0000, 16'h1001);
    wr(`WOLF_IDX_CFG, 16'h1781);
    frame(8'hd5, 2'd0, 1'b0, 16'hffff, 16'h0001, 16'h1001);
    chk_val({15'h0000, wake_o}, 16'h0001);
    wr(`WOLF_IDX_CFG, 16'h1f81);
    repeat (3) @(posedge clk_i);
    chk_val({15'h0000, wake_o}, 16'h0000);
    rdc(`WOLF_IDX_CFG, 16'h1781);
    complete_run;
  end
endmodule

// >>> test/wolf_station_model.sv
// Purpose: remote station that sends wake frames as a byte stream
// Assumes: one byte per clock inside a frame
// Notes:   data line shows the inverse of the last byte between frames
`timescale 1ns/100ps
module wolf_station_model #(
  parameter [47:0] ADDR = 48'h0,
  parameter [47:0] PW   = 48'h0,
  parameter [47:0] PAT  = 48'h0
) (
  input  wire       clk_i,
  input  wire [1:0] swap_i,
  output reg        rx_vld_o,
  output reg  [7:0] rx_data_o,
  output reg        rx_end_o,
  output reg        rx_crc_bad_o
);
  // ************************
  // frame sender
  // ************************
  initial begin
    rx_vld_o = 1'b0;
    rx_data_o = 8'h00;
    rx_end_o = 1'b0;
    rx_crc_bad_o = 1'b0;
  end
  // every swap code is its own inverse, so sending pre-swapped bytes works
  function automatic [7:0] swz(input [7:0] b);
    case (swap_i)
      2'b01: swz = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      2'b10: swz = {b[3:0], b[7:4]};
      2'b11: swz = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      default: swz = b;
    endcase
  endfunction
  task put(input [7:0] b);
    @(posedge clk_i);
    rx_vld_o <= 1'b1;
    rx_data_o <= swz(b);
  endtask
  // kind: 0 magic, 1 magic with good password, 2 bad password, 3 pattern
  task send(input [7:0] sfd, input [1:0] kind, input bad);
    integer i;
    put(8'h55);
    put(8'h55);
    put(sfd);
    if (kind == 2'd3) begin
      for (i = 0; i < 10; i++)
        put((i > 1 && i < 8) ? PAT[47-8*(i-2) -: 8] : 8'h10);
    end else begin
      for (i = 0; i < 6; i++)
        put(8'hff);
      for (i = 0; i < 96; i++)
        put(ADDR[47-8*(i%6) -: 8]);
      for (i = 0; i < 6 && kind != 2'd0; i++)
        put(PW[47-8*i -: 8] ^ {7'h00, kind == 2'd2 && i == 5});
    end
    @(posedge clk_i);
    rx_vld_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
    @(posedge clk_i);
    rx_end_o <= 1'b1;
    rx_crc_bad_o <= bad;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
    rx_crc_bad_o <= ~bad;
  endtask
endmodule
